// ### balu_adder.sv
// Purpose: 8-bit adder with carry and half-carry outputs
// Assumes: combinational, used by the main datapath
// Notes: no state
`include "balu_cfg.svh"
module balu_adder
  import balu_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] sum,
  output logic cout,
  output logic hcout
);
  // Low nibble, its carry out is the half carry
  logic [4:0] low_sum;
  // High nibble including the low carry
  logic [4:0] high_sum;

  // ---------------------------------------------
  // Nibble-split add
  // ---------------------------------------------
  always_comb begin
    low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    high_sum = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low_sum[4]};
    sum = {high_sum[3:0], low_sum[3:0]};
    cout = high_sum[4];
    hcout = low_sum[4];
  end
endmodule

// ### balu_cfg.svh
// Purpose: constants for the byte ALU datapath
// Assumes: one core clock, decode logic supplies operands
// Notes: definitions only
//
// What this block does
// - Pointer add sign-extends 6-bit immediate, flags kept
// - Pointer pair wraps modulo 16 bits
// - AND immediate into accumulator, zero flag only
// - Add immediate into accumulator, C DC Z
// - Add register and accumulator, routed by destination, C DC Z
// - Destination bit picks accumulator or register
// - AND register, routed by destination, Z only
// - Shift right: bits 7:1 down, bit0 to carry
// - Shift keeps sign bit, updates C and Z
// - Add with carry, routed, C DC Z
// - Decrement, store, skip next when zero
`ifndef BALU_CFG_SVH
`define BALU_CFG_SVH
`define BALU_ACC_RST 8'h00
`define BALU_PTR_RST 16'h0000
`define BALU_FLAGS_RST 3'h0
`define BALU_DEST_ACC 1'b0
`define BALU_DEST_REG 1'b1
`define BALU_REG_MAX 7'h7F
`endif

// ### balu_core.sv
// Purpose: execution datapath for byte ALU ops and pointer add
// Assumes: register operand reg_rd_data matches req.addr this cycle
// Notes: results land one cycle after a valid request
`include "balu_cfg.svh"
module balu_core
  import balu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire balu_req_t req,
  input wire logic [7:0] reg_rd_data,
  output balu_wb_t wb_ff,
  output logic [7:0] acc_ff,
  output balu_flags_t flags_ff,
  output logic [15:0] ptr0_ff,
  output logic [15:0] ptr1_ff,
  output logic skip_next_ff,
  output logic done_ff
);
  // ---------------------------------------------
  // Operand and adder selection
  // ---------------------------------------------
  // Adder second operand
  logic [7:0] add_b;
  // Adder carry in
  logic add_cin;
  // Adder outputs
  logic [7:0] add_sum;
  logic add_cout;
  logic add_hc;
  // Computed result and flags
  logic [7:0] nxt_result;
  balu_flags_t nxt_flags;
  // Register-file op flag
  logic is_file_op;
  // Pointer after add
  logic [15:0] nxt_ptr;
  logic [15:0] ptr_sel_val;

  // Zero detect, shared by every flag-updating op
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // Sign-extend a 6-bit immediate to 16 bits
  function automatic logic [15:0] sext6(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction

  // Pick the adder's second operand and carry
  always_comb begin
    add_b = reg_rd_data;
    add_cin = 1'b0;
    if (req.op == BALU_OP_ADD_IMM) begin
      add_b = req.imm;
    end else if (req.op == BALU_OP_ADDC_REG) begin
      add_cin = flags_ff.carry;
    end
  end

  balu_adder u_adder (
    .a(acc_ff),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_cout),
    .hcout(add_hc)
  );

  // ---------------------------------------------
  // Result and flag computation
  // ---------------------------------------------
  always_comb begin
    nxt_result = acc_ff;
    nxt_flags = flags_ff;
    is_file_op = 1'b0;
    case (req.op)
      BALU_OP_AND_IMM: begin
        nxt_result = acc_ff & req.imm;
        nxt_flags.zero = is_zero(nxt_result);
      end
      BALU_OP_ADD_IMM: begin
        nxt_result = add_sum;
        nxt_flags = '{carry: add_cout, half_carry: add_hc, zero: is_zero(add_sum)};
      end
      BALU_OP_ADD_REG, BALU_OP_ADDC_REG: begin
        nxt_result = add_sum;
        is_file_op = 1'b1;
        nxt_flags = '{carry: add_cout, half_carry: add_hc, zero: is_zero(add_sum)};
      end
      BALU_OP_AND_REG: begin
        nxt_result = acc_ff & reg_rd_data;
        is_file_op = 1'b1;
        nxt_flags.zero = is_zero(nxt_result);
      end
      BALU_OP_ASR: begin
        nxt_result = {reg_rd_data[7], reg_rd_data[7:1]};
        is_file_op = 1'b1;
        nxt_flags.carry = reg_rd_data[0];
        nxt_flags.zero = is_zero(nxt_result);
      end
      BALU_OP_DEC_SKIP: begin
        // Flags untouched by decrement-and-skip
        nxt_result = reg_rd_data - 8'h01;
        is_file_op = 1'b1;
      end
      default: begin
        nxt_result = acc_ff;
      end
    endcase
  end

  // ---------------------------------------------
  // Pointer arithmetic
  // ---------------------------------------------
  // Plain 16-bit add, overflow drops off the top
  always_comb begin
    ptr_sel_val = req.ptr_sel ? ptr1_ff : ptr0_ff;
    nxt_ptr = ptr_sel_val + sext6(req.imm[5:0]);
  end

  // ---------------------------------------------
  // Accumulator
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= `BALU_ACC_RST;
    end else if (req.valid) begin
      if (req.op == BALU_OP_AND_IMM || req.op == BALU_OP_ADD_IMM) begin
        acc_ff <= nxt_result;
      end else if (is_file_op && req.dest == `BALU_DEST_ACC) begin
        acc_ff <= nxt_result;
      end
    end
  end

  // ---------------------------------------------
  // Flags
  // ---------------------------------------------
  // Pointer add leaves the flags alone by construction
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= `BALU_FLAGS_RST;
    end else if (req.valid && req.op != BALU_OP_ADD_PTR) begin
      flags_ff <= nxt_flags;
    end
  end

  // ---------------------------------------------
  // Register-file write-back
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ff <= '0;
    end else begin
      wb_ff.wr_en <= req.valid && is_file_op && req.dest == `BALU_DEST_REG;
      wb_ff.addr <= req.addr;
      wb_ff.data <= nxt_result;
    end
  end

  // ---------------------------------------------
  // Indirect pointer pairs
  // ---------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr0_ff <= `BALU_PTR_RST;
      ptr1_ff <= `BALU_PTR_RST;
    end else if (req.valid && req.op == BALU_OP_ADD_PTR) begin
      if (req.ptr_sel) begin
        ptr1_ff <= nxt_ptr;
      end else begin
        ptr0_ff <= nxt_ptr;
      end
    end
  end

  // ---------------------------------------------
  // Skip request and completion
  // ---------------------------------------------
  // Skip tells fetch to turn the next word into a no-op
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_next_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      skip_next_ff <= req.valid && req.op == BALU_OP_DEC_SKIP && is_zero(nxt_result);
      done_ff <= req.valid;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  AST_PTR_FLAGS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_PTR) |=> flags_ff == $past(flags_ff))
    else $error("pointer add changed flags");
  AST_PTR_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_PTR && !req.ptr_sel) |=>
      ptr0_ff == 16'($past(ptr0_ff) + {{10{$past(req.imm[5])}}, $past(req.imm[5:0])}))
    else $error("pointer add wrong");
  AST_ANDI: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_AND_IMM) |=>
      acc_ff == ($past(acc_ff) & $past(req.imm)) && flags_ff.carry == $past(flags_ff.carry))
    else $error("and immediate wrong");
  AST_ADDI: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_IMM) |=>
      {flags_ff.carry, acc_ff} == {1'b0, $past(acc_ff)} + {1'b0, $past(req.imm)})
    else $error("add immediate wrong");
  AST_DEST_REG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_REG && req.dest) |=> wb_ff.wr_en && acc_ff == $past(acc_ff))
    else $error("destination register not honoured");
  AST_ANDR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_AND_REG) |=>
      wb_ff.data == ($past(acc_ff) & $past(reg_rd_data)) && flags_ff.zero == (wb_ff.data == 8'h00))
    else $error("and register wrong");
  AST_ASR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ASR) |=>
      wb_ff.data[7] == $past(reg_rd_data[7]) && flags_ff.carry == $past(reg_rd_data[0]))
    else $error("shift wrong");
  AST_ADDC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADDC_REG) |=>
      wb_ff.data == 8'($past(acc_ff) + $past(reg_rd_data) + {7'h00, $past(flags_ff.carry)}))
    else $error("add with carry wrong");
  AST_SKIP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_DEC_SKIP && reg_rd_data == 8'h01) |=> skip_next_ff)
    else $error("skip missing");

  // ---------------------------------------------
  // Per-operation checks, flags and routing
  // ---------------------------------------------
  // Pair 1 wraps the same way as pair 0
  AST_PTR1_WRAP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_PTR && req.ptr_sel) |=>
      ptr1_ff == 16'($past(ptr1_ff) + {{10{$past(req.imm[5])}}, $past(req.imm[5:0])}))
    else $error("pointer pair 1 add wrong");
  // Pair 0 add leaves pair 1 and the accumulator untouched
  AST_PTR_OTHER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_PTR && !req.ptr_sel) |=>
      ptr1_ff == $past(ptr1_ff) && acc_ff == $past(acc_ff))
    else $error("pointer add disturbed other state");
  // AND immediate sets zero from the new accumulator
  AST_ANDI_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_AND_IMM) |=>
      flags_ff.zero == (acc_ff == 8'h00) && flags_ff.half_carry == $past(flags_ff.half_carry))
    else $error("and immediate flags wrong");
  // Half carry is the carry out of the low nibble
  AST_ADDI_HC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_IMM) |=>
      flags_ff.half_carry == (({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(req.imm[3:0])}) > 5'h0F))
    else $error("add immediate half carry wrong");
  // Zero flag follows the new accumulator
  AST_ADDI_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_IMM) |=>
      flags_ff.zero == (acc_ff == 8'h00))
    else $error("add immediate zero flag wrong");
  // Register add sum, whatever the destination
  AST_ADDR_SUM: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_REG) |=>
      wb_ff.data == 8'($past(acc_ff) + $past(reg_rd_data)))
    else $error("register add sum wrong");
  // Carry is bit 8 of the full sum
  AST_ADDR_CARRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_REG) |=>
      flags_ff.carry == (({1'b0, $past(acc_ff)} + {1'b0, $past(reg_rd_data)}) > 9'h0FF))
    else $error("register add carry wrong");
  // Destination 0 keeps the file register unwritten
  AST_DEST_ACC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADD_REG && !req.dest) |=>
      !wb_ff.wr_en && acc_ff == wb_ff.data)
    else $error("destination accumulator not honoured");
  // Register AND written back leaves carry alone
  AST_ANDR_ROUTE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_AND_REG && req.dest) |=>
      wb_ff.wr_en && flags_ff.carry == $past(flags_ff.carry))
    else $error("and register routing wrong");
  // Low seven result bits come from bits 7:1
  AST_ASR_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ASR) |=>
      wb_ff.data[6:0] == $past(reg_rd_data[7:1]))
    else $error("shift low bits wrong");
  // Zero flag on the shifted value
  AST_ASR_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ASR) |=>
      flags_ff.zero == (wb_ff.data == 8'h00))
    else $error("shift zero flag wrong");
  // Carry in counts toward the carry out
  AST_ADDC_CARRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_ADDC_REG) |=>
      flags_ff.carry ==
        (({1'b0, $past(acc_ff)} + {1'b0, $past(reg_rd_data)} + {8'h00, $past(flags_ff.carry)}) > 9'h0FF))
    else $error("add with carry carry flag wrong");
  // No skip unless the count reaches zero; flags kept
  AST_SKIP_NONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_DEC_SKIP && reg_rd_data != 8'h01) |=>
      !skip_next_ff && flags_ff == $past(flags_ff))
    else $error("unexpected skip or flag change");
  // Decremented value goes out on write-back
  AST_DEC_DATA: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (req.valid && req.op == BALU_OP_DEC_SKIP) |=>
      wb_ff.data == 8'($past(reg_rd_data) - 8'h01))
    else $error("decrement value wrong");
  // An idle cycle writes nothing, raises no skip or done, and leaves the accumulator and flags unchanged
  AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !req.valid |=> !wb_ff.wr_en && !skip_next_ff && !done_ff &&
      acc_ff == $past(acc_ff) && flags_ff == $past(flags_ff))
    else $error("idle cycle changed state");
endmodule

// ### balu_pkg.sv
// Purpose: types for the byte ALU datapath
// Assumes: nothing beyond the config header
// Notes: op codes are one-hot, except BALU_OP_NONE at zero
package balu_pkg;
  // Operation select, one-hot except BALU_OP_NONE, which is all zero
  typedef enum logic [7:0] {
    BALU_OP_NONE = 8'h00,
    BALU_OP_ADD_PTR = 8'h01,
    BALU_OP_AND_IMM = 8'h02,
    BALU_OP_ADD_IMM = 8'h04,
    BALU_OP_ADD_REG = 8'h08,
    BALU_OP_AND_REG = 8'h10,
    BALU_OP_ASR = 8'h20,
    BALU_OP_ADDC_REG = 8'h40,
    BALU_OP_DEC_SKIP = 8'h80
  } balu_op_t;
  // Issued instruction
  typedef struct packed {
    logic valid;
    balu_op_t op;
    logic [7:0] imm;
    logic [6:0] addr;
    logic dest;
    logic ptr_sel;
  } balu_req_t;
  // Status flags
  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
  } balu_flags_t;
  // Register-file write-back
  typedef struct packed {
    logic wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } balu_wb_t;
endpackage

// ### byte_alu_arith_logic_ops_tb.sv
// Purpose: self-checking bench for balu_core
// Assumes: each request answers exactly one cycle later
// Notes: seeded random ops mixed with hand-picked corners
`include "balu_cfg.svh"
module byte_alu_arith_logic_ops_tb
  import balu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Stimulus, outputs and reference state
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  balu_req_t req = '0;
  logic [7:0] reg_rd_data = 8'h00;
  balu_wb_t wb_ff;
  logic [7:0] acc_ff;
  balu_flags_t flags_ff;
  logic [15:0] ptr0_ff, ptr1_ff;
  logic skip_next_ff, done_ff;
  int n_fail = 0;
  int n_tests = 0;
  // Reference model: acc, flags {c,dc,z}, pointer pairs
  logic [7:0] m_acc = 8'h00;
  logic [2:0] m_flg = 3'h0;
  logic [15:0] m_ptr [2] = '{16'h0000, 16'h0000};
  // Expected answer of the request in flight
  logic e_pend = 1'b0;
  logic e_wr, e_skip, e_done;
  logic [6:0] e_addr;
  logic [7:0] e_data;
  // Model state after the request in flight, compared a cycle later
  logic [7:0] m_acc_q;
  logic [2:0] m_flg_q;
  logic [15:0] m_p0_q, m_p1_q;

  always #5 ref_clk = ~ref_clk;

  balu_core uut (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .reg_rd_data(reg_rd_data),
    .wb_ff(wb_ff), .acc_ff(acc_ff), .flags_ff(flags_ff), .ptr0_ff(ptr0_ff), .ptr1_ff(ptr1_ff),
    .skip_next_ff(skip_next_ff), .done_ff(done_ff));

  // ----------------------------------------
  // Compare, verdict and request helpers
  // ----------------------------------------
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic balu_req_t mk(balu_op_t op, logic [7:0] imm, logic dest, logic sel);
    mk = '{valid: 1'b1, op: op, imm: imm, addr: 7'h7F, dest: dest, ptr_sel: sel};
  endfunction

  // Work out the expected answer, updating the model in order
  task model(input balu_req_t r, input logic [7:0] rd);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b, res;
    logic ci, route, to_acc;
    {e_wr, e_skip, route, to_acc, res} = '0;
    e_done = r.valid;
    if (r.valid) begin
      case (r.op)
        BALU_OP_ADD_PTR: m_ptr[r.ptr_sel] = m_ptr[r.ptr_sel] + {{10{r.imm[5]}}, r.imm[5:0]};
        BALU_OP_AND_IMM: begin
          res = m_acc & r.imm;
          m_flg[0] = (res == 8'h00);
          to_acc = 1'b1;
        end
        BALU_OP_ADD_IMM, BALU_OP_ADD_REG, BALU_OP_ADDC_REG: begin
          b = (r.op == BALU_OP_ADD_IMM) ? r.imm : rd;
          ci = (r.op == BALU_OP_ADDC_REG) ? m_flg[2] : 1'b0;
          s = {1'b0, m_acc} + {1'b0, b} + {8'h00, ci};
          h = {1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
          res = s[7:0];
          m_flg = {s[8], h[4], res == 8'h00};
          route = (r.op != BALU_OP_ADD_IMM);
          to_acc = !route;
        end
        BALU_OP_AND_REG: begin
          res = m_acc & rd;
          m_flg[0] = (res == 8'h00);
          route = 1'b1;
        end
        BALU_OP_ASR: begin
          res = {rd[7], rd[7:1]};
          m_flg[2] = rd[0];
          m_flg[0] = (res == 8'h00);
          route = 1'b1;
        end
        BALU_OP_DEC_SKIP: begin
          res = rd - 8'h01;
          e_skip = (res == 8'h00);
          route = 1'b1;
        end
        default: ;
      endcase
      if (route && r.dest) e_wr = 1'b1;
      else if (route || to_acc) m_acc = res;
    end
    e_addr = r.addr;
    e_data = res;
  endtask

  // Drive one request; check the one taken at this edge
  task run_op(input balu_req_t r, input logic [7:0] rd);
    @(posedge ref_clk);
    req <= r;
    reg_rd_data <= rd;
    @(negedge ref_clk);
    if (e_pend) begin
      chk("acc", 16'(m_acc_q), 16'(acc_ff));
      chk("flags", 16'(m_flg_q), 16'(flags_ff));
      chk("ptr0", m_p0_q, ptr0_ff);
      chk("ptr1", m_p1_q, ptr1_ff);
      chk("wr_en", 16'(e_wr), 16'(wb_ff.wr_en));
      if (e_wr) chk("wb", {1'b0, e_addr, e_data}, {1'b0, wb_ff.addr, wb_ff.data});
      chk("skip", 16'(e_skip), 16'(skip_next_ff));
      chk("done", 16'(e_done), 16'(done_ff));
    end
    model(r, rd);
    {m_acc_q, m_flg_q, m_p0_q, m_p1_q} = {m_acc, m_flg, m_ptr[0], m_ptr[1]};
    e_pend = 1'b1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    balu_req_t r;
    void'($urandom(10));
    repeat (8) @(posedge ref_clk);
    chk("rst_acc", 16'h0000, {acc_ff, 5'h00, flags_ff});
    chk("rst_done", 16'h0000, 16'({done_ff, skip_next_ff, wb_ff.wr_en}));
    reset_n <= 1'b1;
    // Corner cases: carries, zero results, wrap, routing
    run_op(mk(BALU_OP_ADD_IMM, 8'h0F, 1'b1, 1'b0), 8'h00);
    run_op(mk(BALU_OP_ADD_REG, 8'h00, 1'b1, 1'b0), 8'h01);
    run_op(mk(BALU_OP_ADD_IMM, 8'hF1, 1'b0, 1'b0), 8'h00);
    run_op(mk(BALU_OP_ADDC_REG, 8'h00, 1'b0, 1'b0), 8'hFF);
    run_op(mk(BALU_OP_ADDC_REG, 8'h00, 1'b1, 1'b0), 8'h0E);
    run_op(mk(BALU_OP_AND_IMM, 8'h00, 1'b1, 1'b0), 8'h00);
    run_op(mk(BALU_OP_ADD_IMM, 8'h80, 1'b0, 1'b0), 8'h00);
    run_op(mk(BALU_OP_AND_REG, 8'h00, 1'b0, 1'b0), 8'h7F);
    run_op(mk(BALU_OP_ASR, 8'h00, 1'b1, 1'b0), 8'h81);
    run_op(mk(BALU_OP_ASR, 8'h00, 1'b0, 1'b0), 8'h01);
    run_op(mk(BALU_OP_DEC_SKIP, 8'h00, 1'b1, 1'b0), 8'h01);
    run_op(mk(BALU_OP_DEC_SKIP, 8'h00, 1'b0, 1'b0), 8'h00);
    run_op(mk(BALU_OP_ADD_PTR, 8'hFF, 1'b0, 1'b0), 8'h00);
    run_op(mk(BALU_OP_ADD_PTR, 8'hC1, 1'b0, 1'b0), 8'h00);
    run_op(mk(BALU_OP_ADD_PTR, 8'h20, 1'b0, 1'b1), 8'h00);
    run_op(mk(BALU_OP_ADD_PTR, 8'h1F, 1'b0, 1'b1), 8'h00);
    run_op(mk(BALU_OP_NONE, 8'h55, 1'b0, 1'b0), 8'h55);
    // Random back-to-back traffic, some idle cycles
    for (int i = 0; i < 600; i++) begin
      r.valid = ($urandom % 8) != 0;
      r.op = balu_op_t'(8'h01 << ($urandom % 8));
      r.imm = 8'($urandom);
      r.addr = 7'($urandom);
      r.dest = 1'($urandom);
      r.ptr_sel = 1'($urandom);
      run_op(r, 8'($urandom));
    end
    run_op('0, 8'h00);
    results();
  end
endmodule
